//--- hw/mev_pkg.sv
package mev_pkg;
    localparam logic [15:0] ADDR_MASK_LOW = 16'he50a;
    localparam logic [15:0] ADDR_MASK_HIGH = 16'he50b;
    localparam logic [15:0] ADDR_PHASE_SRC = 16'he600;
    localparam logic [15:0] ADDR_NOLOAD = 16'he608;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam logic [2:0] PHASE_RESET = 3'h0;
    localparam int B_IDLE_PWR = 0;
    localparam int B_IDLE_APP = 2;
    localparam int B_MISS_V = 3;
    localparam int B_MISS_I = 6;
    localparam int B_CROSS_V = 9;
    localparam int B_CROSS_I = 12;
    localparam int B_RST_DONE = 15;
    localparam int B_DIP = 16;
    localparam int B_HI_I = 17;
    localparam int B_HI_V = 18;
    localparam int B_ORDER = 19;
    localparam int B_PEAK_I = 23;
    localparam int B_PEAK_V = 24;
    // mask bits that gate an event; 15 and reserved bits excluded
    localparam logic [31:0] MASK_USED = 32'h018f_7ffd;
    localparam int S_HI_I = 3;
    localparam int S_HI_V = 9;
    localparam int S_DIP = 12;
    localparam int N_PWR = 0;
    localparam int N_APP = 6;

    typedef struct packed {
        logic [2:0] idle_pwr;
        logic [2:0] idle_app;
        logic [2:0] missed_v;
        logic [2:0] missed_i;
        logic [2:0] cross_v;
        logic [2:0] cross_i;
        logic [2:0] rise_v;
        logic [2:0] dip;
        logic [2:0] hi_i;
        logic [2:0] hi_v;
        logic reset_done;
        logic peak_i_end;
        logic peak_v_end;
    } mev_events_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } mev_req_s;

    typedef enum logic {
        ORD_IDLE,
        ORD_ARMED
    } mev_order_e;
endpackage

//--- hw/mev_event_mask.sv
`timescale 1ns/1ps
`default_nettype none
module mev_event_mask (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire mev_pkg::mev_events_s evt,
    input wire mev_pkg::mev_req_s req,
    input wire logic [31:0] flag_clear,
    output logic [31:0] rdata,
    output logic [31:0] event_flags_high,
    output logic irq_n
);
    logic [31:0] mask_low_reg;
    logic [31:0] mask_high_reg;
    logic [31:0] flags_reg;
    logic [31:0] flags_next;
    logic [31:0] raise;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [2:0] hi_i_ph_reg;
    logic [2:0] hi_v_ph_reg;
    logic [2:0] dip_ph_reg;
    logic [2:0] hi_i_ph_next;
    logic [2:0] hi_v_ph_next;
    logic [2:0] dip_ph_next;
    logic [2:0] idle_pwr_reg;
    logic [2:0] idle_app_reg;
    logic [15:0] src_word;
    logic [15:0] noload_word;
    mev_pkg::mev_order_e ord_reg;
    mev_pkg::mev_order_e ord_next;
    wire wr_low = req.wr && (req.addr == mev_pkg::ADDR_MASK_LOW);
    wire wr_high = req.wr && (req.addr == mev_pkg::ADDR_MASK_HIGH);
    wire order_err = (ord_reg == mev_pkg::ORD_ARMED) && evt.rise_v[2] && !evt.rise_v[1];
    wire enabled_any = |(flags_reg & mask_high_reg & mev_pkg::MASK_USED);

    // event sources mapped onto the high flag word
    assign raise[mev_pkg::B_IDLE_PWR] = |(evt.idle_pwr & ~idle_pwr_reg);
    assign raise[1] = 1'b0;
    assign raise[mev_pkg::B_IDLE_APP] = |(evt.idle_app & ~idle_app_reg);
    assign raise[mev_pkg::B_MISS_V +: 3] = evt.missed_v;
    assign raise[mev_pkg::B_MISS_I +: 3] = evt.missed_i;
    assign raise[mev_pkg::B_CROSS_V +: 3] = evt.cross_v;
    assign raise[mev_pkg::B_CROSS_I +: 3] = evt.cross_i;
    assign raise[mev_pkg::B_RST_DONE] = evt.reset_done;
    assign raise[mev_pkg::B_DIP] = |evt.dip;
    assign raise[mev_pkg::B_HI_I] = |evt.hi_i;
    assign raise[mev_pkg::B_HI_V] = |evt.hi_v;
    assign raise[mev_pkg::B_ORDER] = order_err;
    assign raise[22:20] = 3'h0;
    assign raise[mev_pkg::B_PEAK_I] = evt.peak_i_end;
    assign raise[mev_pkg::B_PEAK_V] = evt.peak_v_end;
    assign raise[31:25] = 7'h00;

    // a new event wins over a clear in the same cycle
    assign flags_next = (flags_reg & ~flag_clear) | raise;

    // phase bits load together with their combined flag
    assign hi_i_ph_next = (flag_clear[mev_pkg::B_HI_I] ? 3'h0 : hi_i_ph_reg) | evt.hi_i;
    assign hi_v_ph_next = (flag_clear[mev_pkg::B_HI_V] ? 3'h0 : hi_v_ph_reg) | evt.hi_v;
    assign dip_ph_next = (flag_clear[mev_pkg::B_DIP] ? 3'h0 : dip_ph_reg) | evt.dip;

    always_comb begin
        src_word = 16'h0000;
        src_word[mev_pkg::S_HI_I +: 3] = hi_i_ph_reg;
        src_word[mev_pkg::S_HI_V +: 3] = hi_v_ph_reg;
        src_word[mev_pkg::S_DIP +: 3] = dip_ph_reg;
    end

    always_comb begin
        noload_word = 16'h0000;
        noload_word[mev_pkg::N_PWR +: 3] = idle_pwr_reg;
        noload_word[mev_pkg::N_APP +: 3] = idle_app_reg;
    end

    always_comb begin
        unique case (req.addr)
            mev_pkg::ADDR_MASK_LOW: rdata_next = mask_low_reg;
            mev_pkg::ADDR_MASK_HIGH: rdata_next = mask_high_reg;
            mev_pkg::ADDR_PHASE_SRC: rdata_next = {16'h0000, src_word};
            mev_pkg::ADDR_NOLOAD: rdata_next = {16'h0000, noload_word};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // phase order watch: arm on rising A, expect B next
    always_comb begin
        ord_next = ord_reg;
        if (evt.rise_v[0]) begin
            ord_next = mev_pkg::ORD_ARMED;
        end else if (evt.rise_v[1] || evt.rise_v[2]) begin
            ord_next = mev_pkg::ORD_IDLE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            mask_low_reg <= mev_pkg::MASK_RESET;
            mask_high_reg <= mev_pkg::MASK_RESET;
            flags_reg <= mev_pkg::MASK_RESET;
            ord_reg <= mev_pkg::ORD_IDLE;
        end else begin
            if (wr_low) begin
                mask_low_reg <= req.wdata;
            end
            if (wr_high) begin
                mask_high_reg <= req.wdata;
            end
            flags_reg <= flags_next;
            ord_reg <= ord_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            hi_i_ph_reg <= mev_pkg::PHASE_RESET;
            hi_v_ph_reg <= mev_pkg::PHASE_RESET;
            dip_ph_reg <= mev_pkg::PHASE_RESET;
            idle_pwr_reg <= mev_pkg::PHASE_RESET;
            idle_app_reg <= mev_pkg::PHASE_RESET;
            rdata_reg <= mev_pkg::MASK_RESET;
        end else begin
            hi_i_ph_reg <= hi_i_ph_next;
            hi_v_ph_reg <= hi_v_ph_next;
            dip_ph_reg <= dip_ph_next;
            idle_pwr_reg <= evt.idle_pwr;
            idle_app_reg <= evt.idle_app;
            if (req.rd) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign rdata = rdata_reg;
    assign event_flags_high = flags_reg;
    // reset-complete bypasses the mask
    assign irq_n = !(enabled_any || flags_reg[mev_pkg::B_RST_DONE]);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_power_idle_irq: assert property (
        ((|(evt.idle_pwr & ~idle_pwr_reg)) && mask_high_reg[mev_pkg::B_IDLE_PWR]
            && !flag_clear[mev_pkg::B_IDLE_PWR]) |=> !irq_n)
        else $error("power idle entry did not raise irq");

    a_apparent_idle_irq: assert property (
        ((|(evt.idle_app & ~idle_app_reg)) && mask_high_reg[mev_pkg::B_IDLE_APP])
            |=> flags_reg[mev_pkg::B_IDLE_APP] && !irq_n)
        else $error("apparent idle entry did not raise irq");

    a_missed_cross_irq: assert property (
        (|({evt.missed_i, evt.missed_v} & mask_high_reg[8:3])) |=> !irq_n)
        else $error("missed crossing did not raise irq");

    a_cross_irq: assert property (
        (|({evt.cross_i, evt.cross_v} & mask_high_reg[14:9])) |=> !irq_n)
        else $error("zero crossing did not raise irq");

    a_reset_done_unmasked: assert property (
        evt.reset_done |=> !irq_n)
        else $error("reset complete did not raise irq");

    a_dip_phase_shown: assert property (
        (evt.dip != 3'h0) |=> flags_reg[mev_pkg::B_DIP]
            && ((dip_ph_reg & $past(evt.dip)) == $past(evt.dip)))
        else $error("dip flag and phase bits not set together");

    a_hi_i_phase_shown: assert property (
        (evt.hi_i != 3'h0) |=> flags_reg[mev_pkg::B_HI_I]
            && ((src_word[5:3] & $past(evt.hi_i)) == $past(evt.hi_i)))
        else $error("high current phase bits wrong");

    a_hi_v_phase_shown: assert property (
        (evt.hi_v != 3'h0) |=> flags_reg[mev_pkg::B_HI_V]
            && ((src_word[11:9] & $past(evt.hi_v)) == $past(evt.hi_v)))
        else $error("high voltage phase bits wrong");

    // rising crossings one phase at a time, with one quiet cycle between them
    sequence s_rise_a;
        evt.rise_v[0] && !evt.rise_v[1] && !evt.rise_v[2];
    endsequence

    sequence s_rise_b;
        evt.rise_v[1] && !evt.rise_v[0] && !evt.rise_v[2];
    endsequence

    sequence s_rise_c;
        evt.rise_v[2] && !evt.rise_v[1] && !evt.rise_v[0];
    endsequence

    sequence s_quiet;
        evt.rise_v == 3'h0;
    endsequence

    sequence s_a_then_c;
        s_rise_a ##1 s_quiet ##1 s_rise_c;
    endsequence

    sequence s_a_b_c;
        s_rise_a ##1 s_quiet ##1 s_rise_b ##1 s_quiet ##1 s_rise_c;
    endsequence

    a_order_error: assert property (
        s_a_then_c |=> flags_reg[mev_pkg::B_ORDER])
        else $error("phase order error not flagged");

    a_order_in_turn: assert property (
        (s_a_b_c ##0 !flags_reg[mev_pkg::B_ORDER]) |=> !flags_reg[mev_pkg::B_ORDER])
        else $error("phase order error raised for correct order");

    a_order_disarm: assert property (
        s_rise_b |=> ord_reg == mev_pkg::ORD_IDLE)
        else $error("rise on phase B did not disarm order watch");

    a_peak_end_irq: assert property (
        ((evt.peak_i_end && mask_high_reg[mev_pkg::B_PEAK_I])
            || (evt.peak_v_end && mask_high_reg[mev_pkg::B_PEAK_V])) |=> !irq_n)
        else $error("peak window end did not raise irq");

    // defined enables listed bit by bit, apart from the package constant
    a_reserved_ignored: assert property (
        (({mask_high_reg[24:23], mask_high_reg[19:16], mask_high_reg[14:2],
            mask_high_reg[0]} == 20'h00000) && !flags_reg[mev_pkg::B_RST_DONE]) |-> irq_n)
        else $error("irq asserted without enabled cause");

    a_src_reserved_zero: assert property (
        (req.rd && req.addr == mev_pkg::ADDR_PHASE_SRC)
            |=> rdata[2:0] == 3'h0 && rdata[8:6] == 3'h0 && rdata[31:15] == 17'h0)
        else $error("phase source reserved bits not zero");

    a_noload_tracks: assert property (
        1'b1 |=> noload_word == {7'h00, $past(evt.idle_app), 3'h0, $past(evt.idle_pwr)})
        else $error("no-load flags do not track phases");

    a_reset_values: assert property (
        disable iff (1'b0) !rstn |=> mask_high_reg == 32'h0 && src_word == 16'h0)
        else $error("mask or phase source not zero after reset");

    a_irq_idle_no_flags: assert property (
        (flags_reg == 32'h0) |-> irq_n)
        else $error("irq asserted with no flag set");

    a_flags_sticky: assert property (
        (flags_reg[mev_pkg::B_HI_V] && !flag_clear[mev_pkg::B_HI_V])
            |=> flags_reg[mev_pkg::B_HI_V])
        else $error("high voltage flag dropped without clear");

    a_set_beats_clear: assert property (
        ((evt.hi_i != 3'h0) && flag_clear[mev_pkg::B_HI_I])
            |=> flags_reg[mev_pkg::B_HI_I] && (hi_i_ph_reg == $past(evt.hi_i)))
        else $error("clear won over a new high current event");

    a_dip_clear: assert property (
        (flag_clear[mev_pkg::B_DIP] && (evt.dip == 3'h0))
            |=> !flags_reg[mev_pkg::B_DIP] && (dip_ph_reg == 3'h0))
        else $error("dip flag or phase bits survived a clear");

    a_missed_flags: assert property (
        1'b1 |=> (flags_reg[8:3] & $past({evt.missed_i, evt.missed_v}))
            == $past({evt.missed_i, evt.missed_v}))
        else $error("missed crossing flag not set");

    a_cross_flags: assert property (
        1'b1 |=> (flags_reg[14:9] & $past({evt.cross_i, evt.cross_v}))
            == $past({evt.cross_i, evt.cross_v}))
        else $error("zero crossing flag not set");

    a_idle_entry_flags: assert property (
        ((evt.idle_pwr & ~idle_pwr_reg) != 3'h0) |=> flags_reg[mev_pkg::B_IDLE_PWR])
        else $error("power idle entry not flagged");

    a_peak_flags: assert property (
        1'b1 |=> (flags_reg[mev_pkg::B_PEAK_I] >= $past(evt.peak_i_end))
            && (flags_reg[mev_pkg::B_PEAK_V] >= $past(evt.peak_v_end)))
        else $error("peak window end not flagged");

    // register port: writes land next cycle, reads show the value before the edge
    a_mask_write_lands: assert property (
        (req.wr && (req.addr == mev_pkg::ADDR_MASK_HIGH))
            |=> mask_high_reg == $past(req.wdata))
        else $error("mask write did not land");

    a_mask_reads_back: assert property (
        (req.rd && (req.addr == mev_pkg::ADDR_MASK_HIGH))
            |=> rdata == $past(mask_high_reg))
        else $error("mask read does not match stored value");

    a_src_reads_phase: assert property (
        (req.rd && (req.addr == mev_pkg::ADDR_PHASE_SRC))
            |=> rdata[14:3] == {$past(dip_ph_reg), $past(hi_v_ph_reg), 3'h0,
            $past(hi_i_ph_reg)})
        else $error("phase source read does not show phase bits");

    a_noload_reserved: assert property (
        (req.rd && (req.addr == mev_pkg::ADDR_NOLOAD))
            |=> (rdata[5:3] == 3'h0) && (rdata[31:9] == 23'h000000))
        else $error("no-load reserved bits not zero");
endmodule
`default_nettype wire

//--- verif/mev_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mev_host_model (
    input wire logic ref_clk,
    input wire logic [31:0] rdata,
    output var mev_pkg::mev_req_s req
);
    initial req = '0;
    // a released bus shows the inverse of its last address and data, with both strobes low
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge ref_clk);
        req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge ref_clk);
        req = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(negedge ref_clk);
        req = '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(negedge ref_clk);
        req = '{addr: ~a, wdata: 32'hffff_ffff, wr: 1'b0, rd: 1'b0};
        d = rdata;
    endtask
endmodule
`default_nettype wire

//--- verif/mev_event_mask_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((ex) !== (got)) begin fail_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module mev_event_mask_bench;
    logic ref_clk;
    logic rstn;
    mev_pkg::mev_events_s evt;
    mev_pkg::mev_req_s req;
    logic [31:0] flag_clear;
    logic [31:0] rdata;
    logic [31:0] event_flags_high;
    logic irq_n;
    logic [31:0] d;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int bits[21] = '{0, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18, 19, 23, 24};

    mev_event_mask mev_event_mask_i (.ref_clk(ref_clk), .rstn(rstn), .evt(evt), .req(req),
        .flag_clear(flag_clear), .rdata(rdata), .event_flags_high(event_flags_high),
        .irq_n(irq_n));
    mev_host_model mev_host_model_i (.ref_clk(ref_clk), .rdata(rdata), .req(req));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic pulse(input mev_pkg::mev_events_s e);
        @(negedge ref_clk);
        evt = e;
        @(negedge ref_clk);
        evt = '0;
    endtask

    task automatic clear(input logic [31:0] c);
        @(negedge ref_clk);
        flag_clear = c;
        @(negedge ref_clk);
        flag_clear = '0;
    endtask

    function automatic mev_pkg::mev_events_s ev_of(input int b);
        mev_pkg::mev_events_s e;
        e = '0;
        if (b == 0) e.idle_pwr = 3'b001;
        if (b == 2) e.idle_app = 3'b001;
        if (b >= 3 && b <= 5) e.missed_v[b-3] = 1'b1;
        if (b >= 6 && b <= 8) e.missed_i[b-6] = 1'b1;
        if (b >= 9 && b <= 11) e.cross_v[b-9] = 1'b1;
        if (b >= 12 && b <= 14) e.cross_i[b-12] = 1'b1;
        if (b == 15) e.reset_done = 1'b1;
        if (b == 16) e.dip = 3'b001;
        if (b == 17) e.hi_i = 3'b001;
        if (b == 18) e.hi_v = 3'b001;
        if (b == 19) e.rise_v = 3'b100;
        if (b == 23) e.peak_i_end = 1'b1;
        if (b == 24) e.peak_v_end = 1'b1;
        return e;
    endfunction

    // enabled alone, or masked with every reserved bit and bit 15 set
    task automatic fire(input int b, input logic en);
        mev_host_model_i.wr(mev_pkg::ADDR_MASK_HIGH, en ? (32'h1 << b) : ~mev_pkg::MASK_USED);
        if (b == 19) pulse('{rise_v: 3'b001, default: '0});
        pulse(ev_of(b));
        `CHK("flag", 1'b1, event_flags_high[b])
        `CHK("irq", !(en || b == 15), irq_n)
        clear(32'h1 << b);
        `CHK("irq clear", 1'b1, irq_n)
    endtask

    initial begin
        rstn = 1'b0;
        evt = '0;
        flag_clear = '0;
        repeat (3) @(negedge ref_clk);
        rstn = 1'b1;
        `CHK("irq reset", 1'b1, irq_n)
        mev_host_model_i.rd(mev_pkg::ADDR_MASK_HIGH, d);
        `CHK("mask high reset", 32'h0, d)
        mev_host_model_i.rd(mev_pkg::ADDR_PHASE_SRC, d);
        `CHK("source reset", 32'h0, d)
        mev_host_model_i.wr(mev_pkg::ADDR_MASK_LOW, 32'h1234_abcd);
        mev_host_model_i.rd(mev_pkg::ADDR_MASK_LOW, d);
        `CHK("mask low", 32'h1234_abcd, d)
        mev_host_model_i.rd(16'he601, d);
        `CHK("unmapped", 32'h0, d)
        $display("test registers done");
        foreach (bits[i]) begin
            fire(bits[i], 1'b0);
            fire(bits[i], 1'b1);
        end
        $display("test masks done");
        pulse('{hi_i: 3'b010, hi_v: 3'b100, dip: 3'b001, default: '0});
        mev_host_model_i.rd(mev_pkg::ADDR_PHASE_SRC, d);
        `CHK("source", 32'h0000_1810, d)
        clear(32'h0007_0000);
        mev_host_model_i.rd(mev_pkg::ADDR_PHASE_SRC, d);
        `CHK("source clear", 32'h0, d)
        pulse('{hi_i: 3'b010, default: '0});
        @(negedge ref_clk);
        evt.hi_i = 3'b001;
        flag_clear = 32'h0002_0000;
        @(negedge ref_clk);
        evt = '0;
        flag_clear = '0;
        `CHK("set wins", 1'b1, event_flags_high[mev_pkg::B_HI_I])
        mev_host_model_i.rd(mev_pkg::ADDR_PHASE_SRC, d);
        `CHK("source reload", 32'h0000_0008, d)
        clear(32'h0002_0000);
        $display("test phase source done");
        @(negedge ref_clk);
        evt.idle_pwr = 3'b101;
        evt.idle_app = 3'b010;
        mev_host_model_i.rd(mev_pkg::ADDR_NOLOAD, d);
        `CHK("noload", 32'h0000_0085, d)
        evt = '0;
        mev_host_model_i.rd(mev_pkg::ADDR_NOLOAD, d);
        `CHK("noload off", 32'h0, d)
        $display("test noload done");
        mev_host_model_i.wr(mev_pkg::ADDR_MASK_HIGH, 32'h0008_0000);
        pulse('{rise_v: 3'b001, default: '0});
        pulse('{rise_v: 3'b010, default: '0});
        pulse('{rise_v: 3'b100, default: '0});
        `CHK("order in turn", 1'b0, event_flags_high[mev_pkg::B_ORDER])
        `CHK("order irq", 1'b1, irq_n)
        $display("test phase order done");
        stop_test();
    end
endmodule
`default_nettype wire
